// ### logic/cdas_pkg.sv
// Package: shared types and constants of the console sequencer
// Overview of operation
// [RQ1] Pending printer/card request preempts console operation
// [RQ2] Aux switch zeroes upper address digits
// [RQ3] Active print buffer scan diverts before dispatch
// [RQ4] Alter first reads addressed byte into halves
// [RQ5] Alter loads data switches, writes byte back
// [RQ6] Alter ends showing address, byte, zero pointers
// [RQ7] Display switch digit selects one of 16
// [RQ8] Register X occupies aux bytes X0, X1
// [RQ9] Digit to pointer, register to address digits
// [RQ10] Display end clears halves, pointer low
// [RQ11] Every operation ends clearing processing latch
// [RQ12] Fill reads byte, two senses form pattern
// [RQ13] Fill writes, increments, checks wrap-around
// [RQ14] Fill updates display or zeroes high digit
// [RQ15] Fill repeats until stop latch is set
// [RQ16] Fill stop zeroes pointer, rereads stop byte
// [RQ17] Single instruction needs aux switch off
// [RQ18] Single instruction loads address from aux 30-31
// [RQ19] Load, no time sharing, stop: save address
// [RQ20] Single instruction sets stop latch before fetch
// [RQ21] Stop latch at fetch zeroes pointers, stops
// [RQ22] Mode decoded at start; stop key sets latch
package cdas_pkg;

	// Mode switch positions handled here; others end at once
	localparam logic [2:0] MODE_STORAGE_ALTER = 3'h1;
	localparam logic [2:0] MODE_REGISTER_DISPLAY = 3'h2;
	localparam logic [2:0] MODE_STORAGE_FILL = 3'h3;
	localparam logic [2:0] MODE_SINGLE_INSTR = 3'h4;

	// Aux storage positions of the next instruction address
	localparam logic [7:0] AUX_NSI_HIGH = 8'h30;
	localparam logic [7:0] AUX_NSI_LOW = 8'h31;
	localparam logic [7:0] AUX_LIMIT = 8'hFF;
	localparam logic [15:0] MAIN_TOP_DEFAULT = 16'h0FFF;

	// Register port byte offsets
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_ADDRESS = 8'h08;
	localparam logic [7:0] OFS_DATA = 8'h0C;
	localparam int CTRL_LOAD_BIT = 0;
	localparam logic CTRL_LOAD_RESET = 1'b0;

	// Operator switches and keys, as seen at the pins
	typedef struct packed {
		logic [3:0] addr_sw1;
		logic [3:0] addr_sw2;
		logic [3:0] addr_sw3;
		logic [3:0] addr_sw4;
		logic [3:0] data_sw1;
		logic [3:0] data_sw2;
		logic [2:0] mode;
		logic aux_sw;
		logic start_key;
		logic stop_key;
		logic io_printer;
		logic io_card;
		logic buffer_scan;
		logic time_sharing;
	} cdas_switch_s;

	// Data registers that serve as the display
	typedef struct packed {
		logic [3:0] address_display_digit;
		logic [3:0] address_extension_digit;
		logic [3:0] address_high_digit;
		logic [3:0] address_middle_digit;
		logic [3:0] address_low_digit;
		logic [3:0] data_upper_half;
		logic [3:0] data_lower_half;
		logic [3:0] pointer_high_half;
		logic [3:0] pointer_low_half;
	} cdas_display_s;

	// Core storage request
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic rd;
		logic wr;
		logic aux;
	} cdas_mem_s;

	localparam cdas_display_s DISPLAY_RESET = '0;
	localparam cdas_mem_s MEM_RESET = '0;

endpackage

// ### logic/cdas_sync.sv
// Three-stage input conditioner for the operator pins
module cdas_sync
	import cdas_pkg::*;
#(
	parameter int WIDTH = 1
) (
	input wire logic sys_clk_in,
	input wire logic reset_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1_reg;
	logic [WIDTH-1:0] stage2_reg;
	logic [WIDTH-1:0] stage3_reg;
	logic [WIDTH-1:0] value_reg;

	// A change counts only when the last two stages agree,
	// which also filters a one-cycle glitch from a key
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		always_ff @(posedge sys_clk_in) begin
			if (reset_in) begin
				stage1_reg[i] <= 1'b0;
				stage2_reg[i] <= 1'b0;
				stage3_reg[i] <= 1'b0;
				value_reg[i] <= 1'b0;
			end else begin
				stage1_reg[i] <= async_in[i];
				stage2_reg[i] <= stage1_reg[i];
				stage3_reg[i] <= stage2_reg[i];
				if (stage2_reg[i] == stage3_reg[i]) begin
					value_reg[i] <= stage3_reg[i];
				end
			end
		end
	end

	assign sync_out = value_reg;

endmodule

// ### logic/cdas_sequencer.sv
// Console display and alter sequencer
module cdas_sequencer
	import cdas_pkg::*;
#(
	parameter logic [15:0] MAIN_TOP = MAIN_TOP_DEFAULT
) (
	input wire logic sys_clk_in,
	input wire logic reset_in,
	input wire cdas_switch_s switch_in,
	input wire logic fetch_done_in,
	input wire logic [7:0] mem_rdata_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output cdas_mem_s mem_out,
	output cdas_display_s display_out,
	output logic processing_latch_out,
	output logic stop_latch_out,
	output logic io_printer_out,
	output logic io_card_out,
	output logic scan_service_out,
	output logic fetch_start_out,
	output logic [31:0] reg_rdata_out
);

	typedef enum logic [4:0] {
		S_IDLE, S_CHK_IO, S_LOAD_ADDR, S_TEST_SCAN, S_DISPATCH,
		S_ACC_W1, S_ACC_W2, S_TAKE_BYTE, S_SENSE1, S_SENSE2,
		S_FILL_INC, S_FILL_TEST, S_FILL_STOP, S_FILL_RESTORE,
		S_RD_SEL, S_RD_B0, S_RD_B1,
		S_SI_AUX, S_SI_RD0, S_SI_B0, S_SI_B1, S_SI_COND,
		S_SI_SAVE1, S_SI_STOPT, S_SI_EXEC, S_STOP
	} cdas_state_e;

	cdas_state_e state_reg;
	cdas_state_e state_next;
	cdas_state_e ret_reg;
	cdas_state_e ret_next;
	cdas_switch_s sw;
	cdas_mem_s mem_reg;
	cdas_mem_s mem_next;
	cdas_display_s dsp_reg;
	logic [7:0] rbyte_reg;
	logic [2:0] mode_reg;
	logic aux_reg;
	logic fill_reg;
	logic proc_reg;
	logic stop_reg;
	logic wrap_reg;
	logic load_reg;
	logic start_prev_reg;
	logic stop_prev_reg;
	logic io_printer_reg;
	logic io_card_reg;
	logic scan_reg;
	logic fetch_reg;
	logic [31:0] rdata_reg;
	logic start_pulse;
	logic stop_pulse;
	logic si_hold;
	logic [15:0] cur_addr;
	logic [15:0] inc_addr;
	logic wrap_hit;

	// Operator pins come from outside the clock domain
	cdas_sync #(
		.WIDTH($bits(cdas_switch_s))
	) u_sync (
		.sys_clk_in(sys_clk_in),
		.reset_in(reset_in),
		.async_in(switch_in),
		.sync_out(sw)
	);

	// Key edges, taken from the conditioned levels
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			start_prev_reg <= 1'b0;
			stop_prev_reg <= 1'b0;
		end else begin
			start_prev_reg <= sw.start_key;
			stop_prev_reg <= sw.stop_key;
		end
	end

	assign start_pulse = sw.start_key && !start_prev_reg;
	assign stop_pulse = sw.stop_key && !stop_prev_reg;

	// Address in the digit registers; extension is zero below 1000
	assign cur_addr = {dsp_reg.address_extension_digit,
		dsp_reg.address_high_digit, dsp_reg.address_middle_digit,
		dsp_reg.address_low_digit};
	// [RQ13] Increment and wrap
	assign wrap_hit = aux_reg ? (cur_addr[7:0] == AUX_LIMIT) :
		(cur_addr == MAIN_TOP);
	assign inc_addr = wrap_hit ? 16'h0000 :
		aux_reg ? {8'h00, cur_addr[7:0] + 8'h01} :
		cur_addr + 16'h0001;
	// [RQ19] Three holding conditions
	assign si_hold = load_reg || !sw.time_sharing || stop_reg;

	// Sequence control and storage requests
	always_comb begin
		state_next = state_reg;
		ret_next = ret_reg;
		mem_next = mem_reg;
		mem_next.rd = 1'b0;
		mem_next.wr = 1'b0;
		unique case (state_reg)
			S_IDLE: begin
				if (start_pulse) begin
					state_next = S_CHK_IO;
				end
			end
			// [RQ1] I/O request first
			S_CHK_IO: begin
				if (sw.io_printer || sw.io_card) begin
					state_next = S_STOP;
				end else begin
					state_next = S_LOAD_ADDR;
				end
			end
			S_LOAD_ADDR: state_next = S_TEST_SCAN;
			// [RQ3] Print buffer scan
			S_TEST_SCAN: begin
				state_next = sw.buffer_scan ? S_STOP : S_DISPATCH;
			end
			// [RQ22] Dispatch on latched mode
			S_DISPATCH: begin
				case (mode_reg)
					MODE_STORAGE_ALTER, MODE_STORAGE_FILL: begin
						// [RQ4] Read addressed byte
						mem_next = '{cur_addr, 8'h00, 1'b1, 1'b0, aux_reg};
						ret_next = S_TAKE_BYTE;
						state_next = S_ACC_W1;
					end
					MODE_REGISTER_DISPLAY: state_next = S_RD_SEL;
					MODE_SINGLE_INSTR: state_next = S_SI_AUX;
					default: state_next = S_STOP;
				endcase
			end
			// Strobe is out during W1, read data is valid in W2
			S_ACC_W1: state_next = S_ACC_W2;
			S_ACC_W2: state_next = ret_reg;
			S_TAKE_BYTE: state_next = S_SENSE1;
			S_SENSE1: state_next = S_SENSE2;
			// [RQ5] Write switch byte back
			S_SENSE2: begin
				mem_next = '{cur_addr, {dsp_reg.data_lower_half,
					sw.data_sw2}, 1'b0, 1'b1, aux_reg};
				ret_next = fill_reg ? S_FILL_INC : S_STOP;
				state_next = S_ACC_W1;
			end
			S_FILL_INC: state_next = S_FILL_TEST;
			// [RQ15] Repeat until stopped
			S_FILL_TEST: begin
				state_next = stop_reg ? S_FILL_STOP : S_DISPATCH;
			end
			// [RQ16] Reread the stop byte
			S_FILL_STOP: begin
				mem_next = '{cur_addr, 8'h00, 1'b1, 1'b0, aux_reg};
				ret_next = S_FILL_RESTORE;
				state_next = S_ACC_W1;
			end
			S_FILL_RESTORE: begin
				mem_next = '{cur_addr, rbyte_reg, 1'b0, 1'b1, aux_reg};
				ret_next = S_STOP;
				state_next = S_ACC_W1;
			end
			// [RQ8] Register X at X0
			S_RD_SEL: begin
				mem_next = '{{8'h00, sw.data_sw1, 4'h0}, 8'h00,
					1'b1, 1'b0, 1'b1};
				ret_next = S_RD_B0;
				state_next = S_ACC_W1;
			end
			// [RQ8] Second byte at X1
			S_RD_B0: begin
				mem_next = '{{8'h00, dsp_reg.pointer_high_half, 4'h1},
					8'h00, 1'b1, 1'b0, 1'b1};
				ret_next = S_RD_B1;
				state_next = S_ACC_W1;
			end
			S_RD_B1: state_next = S_STOP;
			// [RQ17] Main storage only
			S_SI_AUX: state_next = aux_reg ? S_STOP : S_SI_RD0;
			// [RQ18] Entry one address
			S_SI_RD0: begin
				mem_next = '{{8'h00, AUX_NSI_HIGH}, 8'h00,
					1'b1, 1'b0, 1'b1};
				ret_next = S_SI_B0;
				state_next = S_ACC_W1;
			end
			S_SI_B0: begin
				mem_next = '{{8'h00, AUX_NSI_LOW}, 8'h00,
					1'b1, 1'b0, 1'b1};
				ret_next = S_SI_B1;
				state_next = S_ACC_W1;
			end
			S_SI_B1: state_next = S_SI_COND;
			// [RQ19] Save address back
			S_SI_COND: begin
				if (si_hold) begin
					mem_next = '{{8'h00, AUX_NSI_HIGH},
						cur_addr[15:8], 1'b0, 1'b1, 1'b1};
					ret_next = S_SI_SAVE1;
					state_next = S_ACC_W1;
				end else begin
					state_next = S_SI_EXEC;
				end
			end
			S_SI_SAVE1: begin
				mem_next = '{{8'h00, AUX_NSI_LOW},
					cur_addr[7:0], 1'b0, 1'b1, 1'b1};
				ret_next = S_SI_STOPT;
				state_next = S_ACC_W1;
			end
			// [RQ21] Stop at next fetch
			S_SI_STOPT: begin
				if (stop_reg) begin
					state_next = S_STOP;
				end else if (sw.time_sharing && !load_reg) begin
					state_next = S_SI_COND;
				end
			end
			// Instruction runs outside; its return reenters the fetch
			S_SI_EXEC: begin
				if (fetch_done_in) begin
					state_next = S_SI_RD0;
				end
			end
			S_STOP: state_next = S_IDLE;
		endcase
	end

	// Sequencer state and pending return point
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			state_reg <= S_IDLE;
			ret_reg <= S_IDLE;
		end else begin
			state_reg <= state_next;
			ret_reg <= ret_next;
		end
	end

	// Storage port; read byte is caught in the second wait cycle
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			mem_reg <= MEM_RESET;
			rbyte_reg <= 8'h00;
		end else begin
			mem_reg <= mem_next;
			if (state_reg == S_ACC_W2) begin
				rbyte_reg <= mem_rdata_in;
			end
		end
	end

	// Operation latches; a stop key press wins over the start clear
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			proc_reg <= 1'b0;
			stop_reg <= 1'b0;
			wrap_reg <= 1'b0;
			mode_reg <= 3'h0;
			aux_reg <= 1'b0;
			fill_reg <= 1'b0;
		end else begin
			// [RQ22] Mode taken at start
			if (state_reg == S_IDLE && start_pulse) begin
				proc_reg <= 1'b1;
				mode_reg <= sw.mode;
				aux_reg <= sw.aux_sw;
				fill_reg <= (sw.mode == MODE_STORAGE_FILL);
				wrap_reg <= 1'b0;
			end
			// [RQ11] Stop control clears latch
			if (state_reg == S_STOP) begin
				proc_reg <= 1'b0;
			end
			// [RQ20] Set stop latch
			if (stop_pulse || (state_reg == S_SI_COND && !si_hold)) begin
				stop_reg <= 1'b1;
			end else if (state_reg == S_IDLE && start_pulse) begin
				stop_reg <= 1'b0;
			end
			if (state_reg == S_FILL_INC && wrap_hit) begin
				wrap_reg <= 1'b1;
			end
		end
	end

	// Display registers
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			dsp_reg <= DISPLAY_RESET;
		end else begin
			case (state_reg)
				// [RQ2] Aux forces upper digits
				S_LOAD_ADDR: begin
					if (aux_reg) begin
						dsp_reg.address_display_digit <= 4'h0;
						dsp_reg.address_extension_digit <= 4'h0;
						dsp_reg.address_high_digit <= 4'h0;
					end else begin
						dsp_reg.address_display_digit <= sw.addr_sw1;
						dsp_reg.address_extension_digit <= sw.addr_sw1;
						dsp_reg.address_high_digit <= sw.addr_sw2;
					end
					dsp_reg.address_middle_digit <= sw.addr_sw3;
					dsp_reg.address_low_digit <= sw.addr_sw4;
					dsp_reg.pointer_high_half <= 4'h0;
					dsp_reg.pointer_low_half <= 4'h0;
				end
				// [RQ4] Byte into halves
				S_TAKE_BYTE, S_FILL_RESTORE: begin
					dsp_reg.data_upper_half <= rbyte_reg[7:4];
					dsp_reg.data_lower_half <= rbyte_reg[3:0];
				end
				// [RQ12] First sense operation
				S_SENSE1: dsp_reg.data_lower_half <= sw.data_sw1;
				// [RQ6] Second sense, clean pointers
				S_SENSE2: begin
					dsp_reg.data_upper_half <= dsp_reg.data_lower_half;
					dsp_reg.data_lower_half <= sw.data_sw2;
					dsp_reg.pointer_high_half <= 4'h0;
					dsp_reg.pointer_low_half <= 4'h0;
				end
				// [RQ14] Next address and display
				S_FILL_INC: begin
					{dsp_reg.address_extension_digit,
						dsp_reg.address_high_digit,
						dsp_reg.address_middle_digit,
						dsp_reg.address_low_digit} <= inc_addr;
					if (!wrap_hit && !aux_reg) begin
						dsp_reg.address_display_digit <= inc_addr[15:12];
					end else if (!wrap_hit) begin
						dsp_reg.address_high_digit <= 4'h0;
					end
				end
				// [RQ16] Pointer low cleared
				S_FILL_STOP: dsp_reg.pointer_low_half <= 4'h0;
				// [RQ7] One of sixteen
				S_RD_SEL: begin
					dsp_reg.data_lower_half <= sw.data_sw1;
					// [RQ9] Digit into pointer
					dsp_reg.pointer_high_half <= sw.data_sw1;
				end
				// [RQ9] Register to address digits
				S_RD_B0, S_SI_B0: begin
					dsp_reg.address_display_digit <= rbyte_reg[7:4];
					dsp_reg.address_extension_digit <= rbyte_reg[7:4];
					dsp_reg.address_high_digit <= rbyte_reg[3:0];
				end
				S_SI_B1: begin
					dsp_reg.address_middle_digit <= rbyte_reg[7:4];
					dsp_reg.address_low_digit <= rbyte_reg[3:0];
				end
				// [RQ10] Clear halves and pointer low
				S_RD_B1: begin
					dsp_reg.address_middle_digit <= rbyte_reg[7:4];
					dsp_reg.address_low_digit <= rbyte_reg[3:0];
					dsp_reg.data_upper_half <= 4'h0;
					dsp_reg.data_lower_half <= 4'h0;
					dsp_reg.pointer_low_half <= 4'h0;
				end
				// [RQ21] Pointers zero on stop
				S_SI_STOPT: begin
					if (stop_reg) begin
						dsp_reg.pointer_high_half <= 4'h0;
						dsp_reg.pointer_low_half <= 4'h0;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// One-cycle hand-offs to service phases and instruction fetch
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			io_printer_reg <= 1'b0;
			io_card_reg <= 1'b0;
			scan_reg <= 1'b0;
			fetch_reg <= 1'b0;
		end else begin
			// [RQ1] Printer before card machine
			io_printer_reg <= state_reg == S_CHK_IO && sw.io_printer;
			io_card_reg <= state_reg == S_CHK_IO && !sw.io_printer &&
				sw.io_card;
			// [RQ3] Divert to buffer routine
			scan_reg <= state_reg == S_TEST_SCAN && sw.buffer_scan;
			fetch_reg <= state_reg == S_SI_COND && !si_hold;
		end
	end

	// Register port; read data stand only in the cycle after the strobe
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			load_reg <= CTRL_LOAD_RESET;
			rdata_reg <= 32'h0000_0000;
		end else begin
			if (reg_wr_in && reg_addr_in == OFS_CONTROL) begin
				load_reg <= reg_wdata_in[CTRL_LOAD_BIT];
			end
			rdata_reg <= 32'h0000_0000;
			if (reg_rd_in) begin
				case (reg_addr_in)
					OFS_CONTROL: rdata_reg <= {31'h0, load_reg};
					OFS_STATUS: rdata_reg <= {24'h0, state_reg,
						wrap_reg, stop_reg, proc_reg};
					OFS_ADDRESS: rdata_reg <= {12'h0,
						dsp_reg.address_display_digit, cur_addr};
					OFS_DATA: rdata_reg <= {16'h0,
						dsp_reg.data_upper_half, dsp_reg.data_lower_half,
						dsp_reg.pointer_high_half, dsp_reg.pointer_low_half};
					default: rdata_reg <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign mem_out = mem_reg;
	assign display_out = dsp_reg;
	assign processing_latch_out = proc_reg;
	assign stop_latch_out = stop_reg;
	assign io_printer_out = io_printer_reg;
	assign io_card_out = io_card_reg;
	assign scan_service_out = scan_reg;
	assign fetch_start_out = fetch_reg;
	assign reg_rdata_out = rdata_reg;

	// Checks on the sequence
	AST_IO_FIRST: assert property (@(posedge sys_clk_in) // [RQ1]
		disable iff (reset_in)
		state_reg == S_CHK_IO && (sw.io_printer || sw.io_card)
		|=> state_reg == S_STOP ##1 !proc_reg)
		else $error("I/O request did not preempt the operation");

	AST_AUX_ZERO: assert property (@(posedge sys_clk_in) // [RQ2]
		disable iff (reset_in)
		state_reg == S_LOAD_ADDR && aux_reg
		|=> cur_addr[15:8] == 8'h00)
		else $error("Aux address upper digits not zero");

	AST_SCAN: assert property (@(posedge sys_clk_in) // [RQ3]
		disable iff (reset_in)
		state_reg == S_TEST_SCAN && sw.buffer_scan
		|=> scan_service_out && state_reg == S_STOP)
		else $error("Print buffer scan not diverted");

	AST_ALTER_WR: assert property (@(posedge sys_clk_in) // [RQ5]
		disable iff (reset_in)
		state_reg == S_SENSE2 && !fill_reg
		|=> mem_out.wr && mem_out.wdata ==
			{display_out.data_upper_half, display_out.data_lower_half})
		else $error("Altered byte differs from the halves");

	AST_STOP_CLEAR: assert property (@(posedge sys_clk_in) // [RQ11]
		disable iff (reset_in)
		proc_reg && state_reg == S_STOP |=> !proc_reg && state_reg == S_IDLE)
		else $error("Stop control did not clear the latch");

	AST_RD_END: assert property (@(posedge sys_clk_in) // [RQ10]
		disable iff (reset_in)
		state_reg == S_RD_B1 |=> dsp_reg.data_upper_half == 4'h0 &&
			dsp_reg.pointer_low_half == 4'h0 &&
			dsp_reg.pointer_high_half == $past(dsp_reg.pointer_high_half))
		else $error("Register display end state wrong");

	AST_SI_LATCH: assert property (@(posedge sys_clk_in) // [RQ20]
		disable iff (reset_in)
		fetch_start_out |-> stop_reg && state_reg == S_SI_EXEC)
		else $error("Fetch started without stop latch");

	AST_STOP_KEY: assert property (@(posedge sys_clk_in) // [RQ22]
		disable iff (reset_in)
		stop_pulse |=> stop_reg)
		else $error("Stop key did not set the latch");

	AST_FILL_INC: assert property (@(posedge sys_clk_in) // [RQ13]
		disable iff (reset_in)
		state_reg == S_FILL_INC && !wrap_hit && !aux_reg
		|=> cur_addr == $past(cur_addr) + 16'h0001)
		else $error("Fill address not advanced by one");

endmodule

// ### verification/cdas_core_model.sv
// Behavioural core storage, main and auxiliary, seen by the sequencer
module cdas_core_model
	import cdas_pkg::*;
(
	input wire logic sys_clk_in,
	input wire cdas_mem_s mem_in,
	output logic [7:0] rdata_out
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] main_mem [0:65535];
	logic [7:0] aux_mem [0:255];

	// Known contents so every read has a predictable answer
	initial begin
		for (int i = 0; i < 256; i++) begin
			aux_mem[i] = 8'(i) ^ 8'hA5;
		end
		for (int i = 0; i < 65536; i++) begin
			main_mem[i] = 8'(i);
		end
		rdata_out = 8'h00;
	end

	// Read data stand for one cycle only; otherwise the lines toggle,
	// so a late sample by the sequencer cannot pass by luck
	always @(posedge sys_clk_in) begin
		if (mem_in.rd) begin
			if (mem_in.aux) begin
				rdata_out <= aux_mem[mem_in.addr[7:0]];
			end else begin
				rdata_out <= main_mem[mem_in.addr];
			end
		end else begin
			rdata_out <= ~rdata_out;
		end
		if (mem_in.wr && mem_in.aux) begin
			aux_mem[mem_in.addr[7:0]] <= mem_in.wdata;
		end else if (mem_in.wr) begin
			main_mem[mem_in.addr] <= mem_in.wdata;
		end
	end
endmodule

// ### verification/tb_top.sv
// Self-checking bench for the console sequencer
module tb_top
	import cdas_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic sys_clk_in, reset_in, fetch_done, reg_wr, reg_rd;
	logic proc, stopl, io_prn, io_crd, scan, fstart;
	cdas_switch_s sw;
	cdas_mem_s mem;
	cdas_display_s disp;
	logic [7:0] mem_rdata, reg_addr, stop_addr;
	logic [31:0] reg_wdata, reg_rdata, d;
	logic [15:0] fetch_addr;
	int fails, comparisons, n_fetch, n_prn, n_crd, n_scan;

	cdas_sequencer #(.MAIN_TOP(16'h1FFF)) i_cdas_sequencer (
		.sys_clk_in(sys_clk_in), .reset_in(reset_in), .switch_in(sw),
		.fetch_done_in(fetch_done), .mem_rdata_in(mem_rdata),
		.reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
		.reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .mem_out(mem),
		.display_out(disp), .processing_latch_out(proc),
		.stop_latch_out(stopl), .io_printer_out(io_prn),
		.io_card_out(io_crd), .scan_service_out(scan),
		.fetch_start_out(fstart), .reg_rdata_out(reg_rdata));

	cdas_core_model i_cdas_core_model (.sys_clk_in(sys_clk_in),
		.mem_in(mem), .rdata_out(mem_rdata));

	// Free-running 100 MHz clock
	initial begin
		sys_clk_in = 1'b0;
		forever #5 sys_clk_in = ~sys_clk_in;
	end

	// One-cycle pulses are counted on the edge that sees them
	always @(posedge sys_clk_in) begin
		if (fstart === 1'b1) begin
			n_fetch <= n_fetch + 1;
			fetch_addr <= disp[31:16];
		end
		n_prn <= n_prn + int'(io_prn === 1'b1);
		n_crd <= n_crd + int'(io_crd === 1'b1);
		n_scan <= n_scan + int'(scan === 1'b1);
	end

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_in);
	endtask

	task automatic check(input logic [35:0] got, exp, input string what);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what,
				got, exp);
		end
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
		@(posedge sys_clk_in);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge sys_clk_in);
		reg_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
		@(posedge sys_clk_in);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk_in);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask

	// Keys are held long enough to pass the input conditioner
	task automatic run_op(input logic [2:0] m, input logic a,
		input logic [15:0] adr, input logic [7:0] dat);
		@(posedge sys_clk_in);
		sw.mode <= m;
		sw.aux_sw <= a;
		{sw.addr_sw1, sw.addr_sw2, sw.addr_sw3, sw.addr_sw4} <= adr;
		{sw.data_sw1, sw.data_sw2} <= dat;
		sw.start_key <= 1'b1;
		tick(10);
		sw.start_key <= 1'b0;
	endtask

	task automatic wait_idle();
		int k;
		k = 0;
		while (proc !== 1'b0 && k < 5000) begin
			tick(1);
			k++;
		end
		check(36'(k < 5000), 36'h1, "operation end");
		tick(2);
	endtask

	task automatic print_verdict();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Watchdog well beyond the thousand or so cycles the tests need
	initial begin
		tick(20000);
		fails++;
		$display("mismatch at %0t: watchdog expired", $time);
		print_verdict();
	end

	// Main sequence
	initial begin
		sw = '0;
		sw.time_sharing = 1'b1;
		fetch_done = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reset_in = 1'b1;
		tick(8);
		reset_in <= 1'b0;
		reg_read(OFS_CONTROL, d);
		check(d, 32'h0, "control reset");
		reg_read(OFS_STATUS, d);
		check(d, 32'h0, "status reset");
		reg_read(8'h10, d);
		check(d, 32'h0, "unmapped read");
		$display("test registers done");

		run_op(MODE_STORAGE_ALTER, 1'b0, 16'h0123, 8'hA5);
		wait_idle();
		check(i_cdas_core_model.main_mem[16'h0123], 8'hA5, "alter");
		check(disp, 36'h00123A500, "alter display");
		check(proc, 1'b0, "processing latch");
		reg_read(OFS_ADDRESS, d);
		check(d, 32'h0000_0123, "address register");
		reg_read(OFS_DATA, d);
		check(d, 32'h0000_A500, "data register");
		run_op(MODE_STORAGE_ALTER, 1'b1, 16'h0142, 8'h3C);
		wait_idle();
		check(i_cdas_core_model.aux_mem[8'h42], 8'h3C, "aux alter");
		check(i_cdas_core_model.main_mem[16'h0142], 8'h42, "main");
		check(disp[31:0], 32'h00423C00, "aux alter display");
		$display("test storage alter done");

		for (int x = 0; x < 16; x++) begin
			run_op(MODE_REGISTER_DISPLAY, 1'b0, 16'h0000, {4'(x), 4'h0});
			wait_idle();
			check(disp[31:0], {8'(x * 16) ^ 8'hA5, 8'(x * 16 + 1) ^ 8'hA5,
				8'h00, 4'(x), 4'h0}, "register display");
		end
		$display("test register display done");

		run_op(MODE_STORAGE_FILL, 1'b1, 16'h00FC, 8'h5A);
		tick(300);
		sw.stop_key <= 1'b1;
		tick(6);
		sw.stop_key <= 1'b0;
		wait_idle();
		stop_addr = disp[23:16];
		reg_read(OFS_STATUS, d);
		check(d[2], 1'b1, "wrap seen");
		check(disp[31:24], 8'h00, "aux high digits");
		check(disp[15:0], {i_cdas_core_model.aux_mem[stop_addr], 8'h00},
			"stop byte");
		for (int i = 0; i < int'(8'(stop_addr - 8'hFC)); i++) begin
			check(i_cdas_core_model.aux_mem[8'(8'hFC + i)], 8'h5A,
				"fill pattern");
		end
		// Main fill across 0FFF so the extension digit reaches the display
		run_op(MODE_STORAGE_FILL, 1'b0, 16'h0FFE, 8'hC3);
		tick(20);
		sw.stop_key <= 1'b1;
		tick(6);
		sw.stop_key <= 1'b0;
		wait_idle();
		check(i_cdas_core_model.main_mem[16'h0FFF], 8'hC3,
			"main fill");
		check(disp[35:32], 4'h1, "display digit");
		$display("test storage fill done");

		i_cdas_core_model.aux_mem[8'h30] = 8'h01;
		i_cdas_core_model.aux_mem[8'h31] = 8'h24;
		reg_write(OFS_CONTROL, 32'h1);
		reg_read(OFS_CONTROL, d);
		check(d, 32'h1, "load latch");
		run_op(MODE_SINGLE_INSTR, 1'b0, 16'h0000, 8'h00);
		tick(60);
		check(proc, 1'b1, "holding loop");
		check(36'(n_fetch), 36'h0, "no fetch while loading");
		check(disp[31:16], 16'h0124, "address from aux");
		reg_write(OFS_CONTROL, 32'h0);
		for (int k = 0; k < 200 && n_fetch == 0; k++) tick(1);
		check(36'(n_fetch), 36'h1, "one fetch");
		check(fetch_addr, 16'h0124, "fetch address");
		check(stopl, 1'b1, "stop latch set");
		fetch_done <= 1'b1;
		tick(1);
		fetch_done <= 1'b0;
		wait_idle();
		check(disp[7:0], 8'h00, "pointers cleared");
		check(36'(n_fetch), 36'h1, "stopped before next");
		check({i_cdas_core_model.aux_mem[8'h30],
			i_cdas_core_model.aux_mem[8'h31]}, 16'h0124, "saved");
		run_op(MODE_SINGLE_INSTR, 1'b1, 16'h0000, 8'h00);
		wait_idle();
		check(36'(n_fetch), 36'h1, "aux switch blocks");
		$display("test single instruction done");

		// Reset between cases, since a service branch may stay busy
		for (int c = 0; c < 3; c++) begin
			reset_in <= 1'b1;
			tick(4);
			reset_in <= 1'b0;
			sw.io_printer <= (c == 0);
			sw.io_card <= (c < 2);
			sw.buffer_scan <= (c == 2);
			run_op(MODE_STORAGE_ALTER, 1'b0, 16'h0200, 8'hFF);
			tick(40);
			check({4'(n_prn), 4'(n_crd), 4'(n_scan)},
				{4'h1, 4'(c > 0), 4'(c == 2)}, "diversion");
			check(i_cdas_core_model.main_mem[16'h0200], 8'h00,
				"no alter");
			sw.io_printer <= 1'b0;
			sw.io_card <= 1'b0;
			sw.buffer_scan <= 1'b0;
		end
		$display("test diversion done");
		print_verdict();
	end
endmodule
